// File: design/sfa_defs.svh
// Word offsets, bit positions, reset values and timing of the flag area.
`ifndef SFA_DEFS_SVH
`define SFA_DEFS_SVH
`define SFA_NET_RESULT   8'hED
`define SFA_LINK0_BASE   8'hEE
`define SFA_LINK1_BASE   8'hF2
`define SFA_UNUSED       8'hF6
`define SFA_UNIT_BASE    8'hF7
`define SFA_RIO_INFO     8'hFB
`define SFA_CTRL         8'hFC
`define SFA_ALARM        8'hFD
`define SFA_SLOW         8'hFE
`define SFA_PULSE        8'hFF
`define SFA_CTRL_RESET   16'h0000
`define SFA_CTRL_WMASK   16'hFE00
`define SFA_BIT_LVL0_ACT 2
`define SFA_BIT_NET_ERR  3
`define SFA_BIT_NET_EN   4
`define SFA_BIT_LVL1_ACT 5
`define SFA_BIT_HL_R1    6
`define SFA_BIT_HL_CPU   8
`define SFA_BIT_CPU_RST  9
`define SFA_BIT_RETAIN   12
`define SFA_BIT_RACK_RST 13
`define SFA_BIT_OUT_OFF  15
`define SFA_BIT_LOW_BATT 8
`define SFA_BIT_CYCLE    9
`define SFA_BIT_IO_VER   10
`define SFA_BIT_HL_R0    11
`define SFA_BIT_RIO_SUM  12
`define SFA_BIT_ALWAYS1  13
`define SFA_BIT_FIRST    15
`define SFA_BIT_CHECK    0
`define SFA_BIT_RIO_FLAG 3
`define SFA_BIT_STEP     7
`define SFA_MS_CODE      4'hB
`define SFA_CLK_NS       10
`define SFA_TICK_NS      10000000
`define SFA_TICK_CYCLES  (`SFA_TICK_NS / `SFA_CLK_NS)
`define SFA_HALF_20MS    12'h001
`define SFA_HALF_100MS   12'h005
`define SFA_HALF_200MS   12'h00A
`define SFA_HALF_1S      12'h032
`define SFA_HALF_1MIN    12'hBB8
`endif

// File: design/sfa_pkg.sv
// Types shared by the flag area and its users.
package sfa_pkg;
  // Completion codes of a network transfer.
  typedef enum logic [7:0] {
    SFA_NORMAL = 8'h00, SFA_PARAM = 8'h01, SFA_NO_TX = 8'h02,
    SFA_NO_DEST = 8'h03, SFA_BUSY = 8'h04, SFA_TIMEOUT = 8'h05,
    SFA_CTRL_ERR = 8'h06, SFA_SET_ERR = 8'h07, SFA_CPU_ERR = 8'h08
  } sfa_code_e;
  // One remote I/O error report.
  typedef struct packed {
    logic       master_slave;
    logic [3:0] master_order;
    logic       is_master;
    logic [2:0] slave_no;
    logic [7:0] word_setting;
    logic [1:0] multiplier;
    logic       upper_byte;
  } sfa_rio_err_s;
  // Instruction result flags.
  typedef struct packed {
    logic instruction_fault_flag;
    logic carry_flag;
    logic above_flag;
    logic same_value_flag;
    logic below_flag;
  } sfa_result_s;
endpackage

// File: design/sfa_special_flag_area.sv
// Special flag area: status and control words 237 to 255.
`timescale 1ns/100ps
`default_nettype none
`include "sfa_defs.svh"
// How it works
// - Status flags stay off until their condition, except word 253 bit 13, always on.
// - Restart bit on then off restarts unit.
// - Word 252 bits 9 to 15 are writable.
// - Words 237 to 251 become work when absent.
// - Completion code lands in word 237 low.
// - Word 251 steps queued errors per check pulse.
// - Bit 03 shows any remote I/O error.
// - Code B formats master or slave fault.
// - Other codes give setting and multiplier.
// - Bit 04 marks upper byte optical unit.
// - Host link errors at fixed bits.
// - Rack restart ignored for multilevel units.
// - Transfer error and enable flags.
// - Data link active flags per level.
// - Completion codes zero through eight.
// - Word 253 low holds fault alarm code.
// - Word 253 carries system error flags.
// - Clock pulse bits in words 254, 255.
// - Word 255 holds instruction result flags.
// - Words 247 to 250 hold unit or level 1 status.
// - Output off bit forces outputs off.
// - Retention bit decides clear on mode change.
module sfa_special_flag_area
  import sfa_pkg::*;
#(
  parameter int RIO_QDEPTH  = 8,
  parameter int OUT_W       = 16,
  parameter int TICK_CYCLES = `SFA_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic                   CLK,
  input  wire logic                   SYS_RST,
  // Word access from the user program.
  input  wire logic                   ACC_EN,
  input  wire logic                   ACC_WE,
  input  wire logic [7:0]             ACC_ADDR,
  input  wire logic [15:0]            ACC_WDATA,
  input  wire logic [15:0]            ACC_WMASK,
  output logic      [15:0]            ACC_RDATA,
  output logic                        ACC_RVALID,
  // Configuration of the link systems.
  input  wire logic                   CFG_NET_PRESENT,
  input  wire logic                   CFG_NET_LVL1_ALT,
  input  wire logic                   CFG_PCLINK_PRESENT,
  input  wire logic                   CFG_RIO_PRESENT,
  input  wire logic                   CFG_HL_MULTILEVEL,
  // Network link reports.
  input  wire logic                   NET_DONE,
  input  wire sfa_code_e              NET_CODE,
  input  wire logic                   NET_ENABLE,
  input  wire logic                   LINK0_ACTIVE,
  input  wire logic                   LINK1_ACTIVE,
  input  wire logic [3:0][15:0]       LINK0_STATUS,
  input  wire logic [3:0][15:0]       LINK1_STATUS,
  input  wire logic [3:0][15:0]       UNIT_FLAGS,
  // Remote I/O error reports.
  input  wire logic                   RIO_ERR_VALID,
  input  wire sfa_rio_err_s           RIO_ERR_INFO,
  // Host link reports and restarts.
  input  wire logic                   HL_RACK_L0_ERR,
  input  wire logic                   HL_RACK_L1_ERR,
  input  wire logic                   HL_CPU_ERR,
  output logic                        HL_CPU_RESTART,
  output logic                        HL_RACK_RESTART,
  // System reports.
  input  wire logic                   FAL_VALID,
  input  wire logic [7:0]             FAL_CODE,
  input  wire logic                   LOW_BATT,
  input  wire logic                   CYCLE_ERR,
  input  wire logic                   IO_VERIFY_ERR,
  input  wire logic                   FIRST_CYCLE,
  input  wire logic                   STEP_FLAG,
  input  wire logic                   RES_VALID,
  input  wire sfa_result_s            RES_FLAGS,
  // Outputs and mode changes.
  input  wire logic [OUT_W-1:0]       OUT_IMAGE,
  output logic      [OUT_W-1:0]       OUT_PHYS,
  input  wire logic                   MODE_CHANGE,
  output logic                        IO_CLEAR
);

  localparam int QW = $clog2(RIO_QDEPTH);

  // Refuse sizes the queue and divider cannot serve.
  initial begin
    if (RIO_QDEPTH < 2 || (1 << QW) != RIO_QDEPTH)
      $error("RIO_QDEPTH must be a power of two, at least 2.");
    if (OUT_W < 1 || TICK_CYCLES < 1)
      $error("OUT_W and TICK_CYCLES must be positive.");
  end

  // Merge masked write data into a stored word.
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] val,
                                        input logic [15:0] msk);
    merge = (old & ~msk) | (val & msk);
  endfunction

  // Lay one remote I/O report out in the shown word.
  function automatic logic [15:0] rio_fmt(input sfa_rio_err_s e);
    if (e.master_slave) begin
      rio_fmt = {`SFA_MS_CODE, e.master_order, e.is_master,
                 e.slave_no, 4'h0};
    end else begin
      rio_fmt = {e.word_setting, 1'b0, e.multiplier,
                 e.upper_byte, 4'h0};
    end
  endfunction

  // Stored state.
  logic [15:0]    ctrl;                 // Control half of word 252.
  logic [15:0]    work [15];            // Work bits of words 237..251.
  sfa_code_e      net_code;             // Last completion code.
  logic           net_err;              // Transfer error flag of the last transfer.
  logic [7:0]     fal_code;             // Last fault alarm number.
  sfa_result_s    result;               // Last instruction results.
  logic           check_bit;            // Error check bit in word 251.
  sfa_rio_err_s   rio_q [RIO_QDEPTH];   // Pending remote I/O errors.
  logic [QW-1:0]  rio_rd;               // Oldest report.
  logic [QW-1:0]  rio_wr;               // Next free slot.
  logic [QW:0]    rio_cnt;              // Reports held.
  logic           cpu_rst_q;            // Previous CPU restart bit.
  logic           rack_rst_q;           // Previous rack restart bit.
  logic [31:0]    tick_cnt;             // Base divider count.
  logic           tick;                 // One pulse per 10 ms.
  logic [11:0]    pcnt [5];             // Half period counters.
  logic [4:0]     pulse;                // Clock pulse bits.

  // Half periods in ticks of the 20 ms, 100 ms, 200 ms, 1 s, 1 min pulses.
  localparam logic [11:0] HALF [5] = '{`SFA_HALF_20MS, `SFA_HALF_100MS,
    `SFA_HALF_200MS, `SFA_HALF_1S, `SFA_HALF_1MIN};

  // Address decode.
  wire        acc_wr   = ACC_EN & ACC_WE;
  wire [7:0]  off      = ACC_ADDR - `SFA_NET_RESULT;
  wire [3:0]  widx     = off[3:0];
  wire [7:0]  l0_off   = ACC_ADDR - `SFA_LINK0_BASE;
  wire [1:0]  sub      = l0_off[1:0];
  wire        in_work  = (ACC_ADDR >= `SFA_NET_RESULT) &&
                         (ACC_ADDR <= `SFA_RIO_INFO);
  wire [7:0]  u_off    = ACC_ADDR - `SFA_UNIT_BASE;
  wire [7:0]  l1_off   = ACC_ADDR - `SFA_LINK1_BASE;
  wire [1:0]  u_sub    = u_off[1:0];
  wire [1:0]  l1_sub   = l1_off[1:0];
  wire        is_net   = ACC_ADDR == `SFA_NET_RESULT;
  wire        is_l0    = (ACC_ADDR >= `SFA_LINK0_BASE) &&
                         (ACC_ADDR <  `SFA_LINK1_BASE);
  wire        is_l1    = (ACC_ADDR >= `SFA_LINK1_BASE) &&
                         (ACC_ADDR <  `SFA_UNUSED);
  wire        is_unit  = (ACC_ADDR >= `SFA_UNIT_BASE) &&
                         (ACC_ADDR <  `SFA_RIO_INFO);
  wire        is_rio   = ACC_ADDR == `SFA_RIO_INFO;

  // Which link system owns the addressed word; absent means work bits.
  wire        unit_own = CFG_PCLINK_PRESENT |
                         (CFG_NET_PRESENT & ~CFG_NET_LVL1_ALT);
  wire        l1_alt   = CFG_NET_PRESENT & CFG_NET_LVL1_ALT;
  wire        owned    = ((is_net | is_l0 | is_l1) & CFG_NET_PRESENT) |
                         (is_unit & (CFG_PCLINK_PRESENT | l1_alt)) |
                         (is_rio & CFG_RIO_PRESENT);
  wire        work_sel = in_work & ~owned;

  // Remote I/O queue control.
  wire        rio_full  = rio_cnt == RIO_QDEPTH[QW:0];
  wire        rio_any   = rio_cnt != '0;
  wire        check_wr  = acc_wr & is_rio & CFG_RIO_PRESENT &
                          ACC_WMASK[`SFA_BIT_CHECK];
  wire        next_check = check_wr ? ACC_WDATA[`SFA_BIT_CHECK]
                                    : check_bit;
  wire        rio_pop   = check_bit & ~next_check & rio_any;
  wire        rio_push  = RIO_ERR_VALID & CFG_RIO_PRESENT & ~rio_full;
  wire [15:0] rio_word  = (rio_any ? (rio_fmt(rio_q[rio_rd]) |
                           (16'h0001 << `SFA_BIT_RIO_FLAG)) : 16'h0000) |
                          {15'h0000, check_bit};

  // Control word writes touch only the control bits.
  wire [15:0] ctrl_msk  = ACC_WMASK & `SFA_CTRL_WMASK;
  wire        ctrl_wr   = acc_wr & (ACC_ADDR == `SFA_CTRL);

  // Device words as the program reads them.
  wire [15:0] w252 = (ctrl & `SFA_CTRL_WMASK) |
    ({15'h0000, LINK0_ACTIVE}   << `SFA_BIT_LVL0_ACT) |
    ({15'h0000, net_err}        << `SFA_BIT_NET_ERR) |
    ({15'h0000, NET_ENABLE}     << `SFA_BIT_NET_EN) |
    ({15'h0000, LINK1_ACTIVE}   << `SFA_BIT_LVL1_ACT) |
    ({15'h0000, HL_RACK_L1_ERR} << `SFA_BIT_HL_R1) |
    ({15'h0000, HL_CPU_ERR}     << `SFA_BIT_HL_CPU);
  wire [15:0] w253 = {8'h00, fal_code} |
    ({15'h0000, LOW_BATT}       << `SFA_BIT_LOW_BATT) |
    ({15'h0000, CYCLE_ERR}      << `SFA_BIT_CYCLE) |
    ({15'h0000, IO_VERIFY_ERR}  << `SFA_BIT_IO_VER) |
    ({15'h0000, HL_RACK_L0_ERR} << `SFA_BIT_HL_R0) |
    ({15'h0000, rio_any}        << `SFA_BIT_RIO_SUM) |
    (16'h0001                   << `SFA_BIT_ALWAYS1) |
    ({15'h0000, FIRST_CYCLE}    << `SFA_BIT_FIRST);
  wire [15:0] w254 = {8'h00, STEP_FLAG, 5'h00, pulse[0], pulse[4]};
  wire [15:0] w255 = {8'h00, result.below_flag,
    result.same_value_flag, result.above_flag, result.carry_flag,
    result.instruction_fault_flag, pulse[3], pulse[2], pulse[1]};
  wire [15:0] w247 = unit_own ? UNIT_FLAGS[u_sub]
                              : (l1_alt ? LINK1_STATUS[u_sub] : 16'h0000);

  // Read selection; unmapped words read zero, unused word 246 reads its work bits.
  wire [15:0] rd_word =
    work_sel                   ? work[widx] :
    is_net                     ? {8'h00, net_code} :
    is_l0                      ? LINK0_STATUS[sub] :
    is_l1                      ? (l1_alt ? 16'h0000 : LINK1_STATUS[l1_sub]) :
    is_unit                    ? w247 :
    is_rio                     ? rio_word :
    ACC_ADDR == `SFA_CTRL      ? w252 :
    ACC_ADDR == `SFA_ALARM     ? w253 :
    ACC_ADDR == `SFA_SLOW      ? w254 :
    ACC_ADDR == `SFA_PULSE     ? w255 : 16'h0000;

  // Read port: data one cycle after the request.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ACC_RDATA  <= 16'h0000;
      ACC_RVALID <= 1'b0;
    end else begin
      ACC_RVALID <= ACC_EN & ~ACC_WE;
      if (ACC_EN & ~ACC_WE) begin
        ACC_RDATA <= rd_word;
      end
    end
  end

  // Work bits; writes to a word owned by a present system are dropped.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < 15; i++) begin
        work[i] <= 16'h0000;
      end
    end else if (acc_wr & work_sel) begin
      work[widx] <= merge(work[widx], ACC_WDATA, ACC_WMASK);
    end
  end

  // Control bits follow set and clear writes only; flags are not stored.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl <= `SFA_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= merge(ctrl, ACC_WDATA, ctrl_msk);
    end
  end

  // Restart pulses on the falling edge of each restart bit; no rack pulse while multilevel is set.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cpu_rst_q       <= 1'b0;
      rack_rst_q      <= 1'b0;
      HL_CPU_RESTART  <= 1'b0;
      HL_RACK_RESTART <= 1'b0;
    end else begin
      cpu_rst_q       <= ctrl[`SFA_BIT_CPU_RST];
      rack_rst_q      <= ctrl[`SFA_BIT_RACK_RST];
      HL_CPU_RESTART  <= cpu_rst_q & ~ctrl[`SFA_BIT_CPU_RST];
      // Multilevel rack units restart by their own means.
      HL_RACK_RESTART <= rack_rst_q & ~ctrl[`SFA_BIT_RACK_RST] &
                         ~CFG_HL_MULTILEVEL;
    end
  end

  // Completion code and transfer error; a failure sets, a normal end clears.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      net_code <= SFA_NORMAL;
      net_err  <= 1'b0;
    end else if (NET_DONE) begin
      net_code <= NET_CODE;
      net_err  <= NET_CODE != SFA_NORMAL;
    end
  end

  // Fault alarm number and instruction results.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fal_code <= 8'h00;
      result   <= '0;
    end else begin
      if (FAL_VALID) begin
        fal_code <= FAL_CODE;
      end
      if (RES_VALID) begin
        result <= RES_FLAGS;
      end
    end
  end

  // Error queue; a report arriving while full is lost, so size it well.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      check_bit <= 1'b0;
      rio_rd    <= '0;
      rio_wr    <= '0;
      rio_cnt   <= '0;
    end else begin
      check_bit <= next_check;
      if (rio_push) begin
        rio_q[rio_wr] <= RIO_ERR_INFO;
        rio_wr        <= rio_wr + 1'b1;
      end
      if (rio_pop) begin
        rio_rd <= rio_rd + 1'b1;
      end
      rio_cnt <= rio_cnt + {{QW{1'b0}}, rio_push} - {{QW{1'b0}}, rio_pop};
    end
  end

  // Base divider giving one enable pulse per 10 ms.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b0;
    end else begin
      tick     <= tick_cnt == 32'(TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h00000000
                                                     : tick_cnt + 1'b1;
    end
  end

  // Each pulse bit toggles after its half period, giving even duty.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pulse <= 5'h00;
      for (int i = 0; i < 5; i++) begin
        pcnt[i] <= 12'h000;
      end
    end else if (tick) begin
      for (int i = 0; i < 5; i++) begin
        if (pcnt[i] == HALF[i] - 12'h001) begin
          pcnt[i]  <= 12'h000;
          pulse[i] <= ~pulse[i];
        end else begin
          pcnt[i] <= pcnt[i] + 12'h001;
        end
      end
    end
  end

  // Physical outputs and mode change clearing.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      OUT_PHYS <= '0;
      IO_CLEAR <= 1'b0;
    end else begin
      OUT_PHYS <= ctrl[`SFA_BIT_OUT_OFF] ? '0 : OUT_IMAGE;
      IO_CLEAR <= MODE_CHANGE & ~ctrl[`SFA_BIT_RETAIN];
    end
  end

endmodule
`default_nettype wire

// File: design/sfa_unused_guard.sv
// No logic here; the flag area module holds it all.

// File: tb/sfa_checker.sv
// Port checker for the special flag area, bound to the top module.
`timescale 1ns/100ps
`default_nettype none
`include "sfa_defs.svh"
module sfa_checker #(
  parameter int OUT_W = 16
) (
  // Clock and reset.
  input wire logic             CLK,
  input wire logic             SYS_RST,
  // Word access.
  input wire logic             ACC_EN,
  input wire logic             ACC_WE,
  input wire logic [7:0]       ACC_ADDR,
  input wire logic [15:0]      ACC_WDATA,
  input wire logic [15:0]      ACC_WMASK,
  input wire logic [15:0]      ACC_RDATA,
  input wire logic             ACC_RVALID,
  // Configuration, host link and outputs.
  input wire logic             CFG_NET_PRESENT,
  input wire logic             CFG_HL_MULTILEVEL,
  input wire logic             HL_RACK_L0_ERR,
  input wire logic             HL_CPU_RESTART,
  input wire logic             HL_RACK_RESTART,
  input wire logic [OUT_W-1:0] OUT_IMAGE,
  input wire logic [OUT_W-1:0] OUT_PHYS,
  input wire logic             MODE_CHANGE,
  input wire logic             IO_CLEAR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic        rd;        // Read taken.
  logic        wr_ctl;    // Control word write taken.
  logic [15:0] ctl;       // Mirror of the control bits.
  logic [15:0] next_ctl;  // Mirror after this write.
  logic [15:0] wm;        // Mask cut to control bits.
  logic        cpu_fall;  // CPU restart bit falls.
  logic        rack_fall; // Rack restart bit falls.
  assign rd = ACC_EN && !ACC_WE;
  assign wr_ctl = ACC_EN && ACC_WE && (ACC_ADDR == `SFA_CTRL);
  assign wm = ACC_WMASK & `SFA_CTRL_WMASK;
  assign next_ctl = wr_ctl ? ((ctl & ~wm) | (ACC_WDATA & wm)) : ctl;
  assign cpu_fall = wr_ctl && ctl[9] && !next_ctl[9];
  assign rack_fall = wr_ctl && ctl[13] && !next_ctl[13];
  // The mirror lets output and clear checks know the control state.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      ctl <= `SFA_CTRL_RESET;
    else
      ctl <= next_ctl;
  end
  rd_answer_a: assert property (rd |=> ACC_RVALID) else $error("no answer");
  no_stray_a: assert property (!rd |=> !ACC_RVALID) else $error("stray");
  rdata_hold_a: assert property (!ACC_RVALID |-> $stable(ACC_RDATA))
    else $error("data moved");
  unmapped_zero_a: assert property (rd && ACC_ADDR < `SFA_NET_RESULT
    |=> ACC_RDATA == 16'h0000) else $error("unmapped not zero");
  code_high_a: assert property (
    rd && CFG_NET_PRESENT && ACC_ADDR == `SFA_NET_RESULT
    |=> ACC_RDATA[15:8] == 8'h00) else $error("code high byte");
  fixed_flags_a: assert property (
    rd && ACC_ADDR == `SFA_ALARM |=> ACC_RDATA[14:13] == 2'h1)
    else $error("fixed flags");
  level0_err_a: assert property (
    rd && ACC_ADDR == `SFA_ALARM |=> ACC_RDATA[11] == $past(HL_RACK_L0_ERR))
    else $error("level 0 error");
  out_off_a: assert property (ctl[15] |=> OUT_PHYS == '0)
    else $error("outputs on");
  out_follow_a: assert property (
    !ctl[15] |=> OUT_PHYS == $past(OUT_IMAGE)) else $error("no refresh");
  clear_mode_a: assert property (
    MODE_CHANGE |=> IO_CLEAR == !$past(ctl[12])) else $error("clear wrong");
  clear_idle_a: assert property (!MODE_CHANGE |=> !IO_CLEAR)
    else $error("stray clear");
  cpu_restart_a: assert property (
    cpu_fall |-> ##[1:3] HL_CPU_RESTART) else $error("no cpu restart");
  rack_restart_a: assert property (
    rack_fall && !CFG_HL_MULTILEVEL |-> ##[1:3] HL_RACK_RESTART)
    else $error("no rack restart");
  rack_multi_a: assert property (
    CFG_HL_MULTILEVEL [*4] |-> !HL_RACK_RESTART)
    else $error("multilevel restart");
  cover property (rd && ACC_ADDR == `SFA_RIO_INFO);
  cover property (HL_CPU_RESTART);
  cover property (MODE_CHANGE && ctl[12]);
endmodule
bind sfa_special_flag_area sfa_checker #(.OUT_W(OUT_W)) u_chk (.*);
`default_nettype wire

// File: tb/sfa_special_flag_area_tb.sv
// Self-checking bench for the special flag area.
`timescale 1ns/100ps
`default_nettype none
`include "sfa_defs.svh"
module sfa_special_flag_area_tb
  import sfa_pkg::*;
();
  logic             clk = 1'b0;          // Bench clock.
  logic             rst = 1'b1;          // Reset, active high.
  logic             en, we;              // Access strobe, write select.
  logic [7:0]       addr;                // Word address.
  logic [15:0]      wdata, wmask, rdata; // Access data.
  logic             rvalid;              // Read answer strobe.
  logic             net_p, alt, pcl_p, rio_p, multi; // Configuration.
  logic             net_done, net_en, l0_act, l1_act; // Network.
  sfa_code_e        net_code;            // Completion code.
  logic [3:0][15:0] l0_st, l1_st, unit_fl; // Status word sets.
  logic             rio_v;               // Remote I/O report strobe.
  sfa_rio_err_s     rio_info;            // Remote I/O report.
  logic             hl_l0, hl_l1, hl_cpu, cpu_rst, rack_rst; // Host link.
  logic             fal_v, batt, cyc, iover, first, step, res_v;
  logic [7:0]       fal_code;            // Alarm number.
  sfa_result_s      res;                 // Instruction results.
  logic [15:0]      img, phys;           // Output image and pins.
  logic             mode, io_clr;        // Mode change and clear.
  int               fail_count = 0;      // Mismatches seen.
  int               checks_done = 0;     // Comparisons made.
  always #5 clk = ~clk;
  sfa_special_flag_area #(.TICK_CYCLES(4)) u_dut (
    .CLK(clk), .SYS_RST(rst), .ACC_EN(en), .ACC_WE(we), .ACC_ADDR(addr),
    .ACC_WDATA(wdata), .ACC_WMASK(wmask), .ACC_RDATA(rdata),
    .ACC_RVALID(rvalid), .CFG_NET_PRESENT(net_p), .CFG_NET_LVL1_ALT(alt),
    .CFG_PCLINK_PRESENT(pcl_p), .CFG_RIO_PRESENT(rio_p),
    .CFG_HL_MULTILEVEL(multi), .NET_DONE(net_done), .NET_CODE(net_code),
    .NET_ENABLE(net_en), .LINK0_ACTIVE(l0_act), .LINK1_ACTIVE(l1_act),
    .LINK0_STATUS(l0_st), .LINK1_STATUS(l1_st), .UNIT_FLAGS(unit_fl),
    .RIO_ERR_VALID(rio_v), .RIO_ERR_INFO(rio_info), .HL_RACK_L0_ERR(hl_l0),
    .HL_RACK_L1_ERR(hl_l1), .HL_CPU_ERR(hl_cpu), .HL_CPU_RESTART(cpu_rst),
    .HL_RACK_RESTART(rack_rst), .FAL_VALID(fal_v), .FAL_CODE(fal_code),
    .LOW_BATT(batt), .CYCLE_ERR(cyc), .IO_VERIFY_ERR(iover),
    .FIRST_CYCLE(first), .STEP_FLAG(step), .RES_VALID(res_v),
    .RES_FLAGS(res), .OUT_IMAGE(img), .OUT_PHYS(phys), .MODE_CHANGE(mode),
    .IO_CLEAR(io_clr));
  // Compares one value and counts the outcome.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One access, held from a falling edge across the taking edge.
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [15:0] d, input logic [15:0] m);
    @(negedge clk);
    en = 1'b1;
    we = w;
    addr = a;
    wdata = d;
    wmask = m;
    @(negedge clk);
    en = 1'b0;
    we = 1'b0;
  endtask
  // Reads a word and compares its masked bits, all of them by default.
  task automatic rc(input logic [7:0] a, input logic [15:0] e,
                    input logic [15:0] m = 16'hFFFF);
    acc(1'b0, a, 16'h0000, 16'h0000);
    chk({15'h0000, rvalid}, 16'h0001);
    chk(rdata & m, e);
  endtask
  // Optional mode change pulse, then counts the three output pulses;
  // sampling starts at once, so a pulse right after a write is seen.
  task automatic watch(input logic mc, input logic [15:0] e);
    int c, r, i;
    c = 0;
    r = 0;
    i = 0;
    mode = mc;
    for (int k = 0; k < 6; k++) begin
      c += (cpu_rst === 1'b1);
      r += (rack_rst === 1'b1);
      i += (io_clr === 1'b1);
      @(negedge clk);
      if (k == 0) mode = 1'b0;
    end
    chk(16'({c[3:0], r[3:0], i[3:0]}), e);
  endtask
  // Streams reads every cycle and counts changes of one bit.
  task automatic tr(input logic [7:0] a, input int b, input int n,
                    input int e);
    int   t;
    logic p;
    t = 0;
    @(negedge clk);
    en = 1'b1;
    addr = a;
    @(negedge clk);
    p = rdata[b];
    repeat (n) begin
      @(negedge clk);
      t += (rdata[b] !== p);
      p = rdata[b];
    end
    en = 1'b0;
    chk(16'(t), 16'(e));
  endtask
  task automatic push(input sfa_rio_err_s e);
    @(negedge clk);
    rio_v = 1'b1;
    rio_info = e;
    @(negedge clk);
    rio_v = 1'b0;
  endtask
  task automatic t_reset();
    chk({12'h000, cpu_rst, rack_rst, io_clr, rvalid}, 16'h0000);
    rc(`SFA_CTRL, 16'h0000);
    rc(`SFA_ALARM, 16'h2000);
    rc(`SFA_RIO_INFO, 16'h0000);
    rc(8'h10, 16'h0000);
  endtask
  // Every completion code, then a normal end clears the error flag.
  task automatic t_net();
    net_p = 1'b1;
    for (int k = 0; k <= 9; k++) begin
      net_done = 1'b1;
      net_code = sfa_code_e'(k % 9);
      @(negedge clk);
      net_done = 1'b0;
      rc(`SFA_NET_RESULT, 16'(k % 9));
      rc(`SFA_CTRL, (k % 9 == 0) ? 16'h0000 : 16'h0008, 16'h0008);
    end
    {net_en, l0_act, l1_act, hl_l1, hl_cpu} = 5'h1F;
    rc(`SFA_CTRL, 16'h0174, 16'h01FF);
    {net_en, l0_act, l1_act, hl_l1, hl_cpu} = 5'h00;
    rc(`SFA_CTRL, 16'h0000, 16'h01FF);
  endtask
  // Owned words show status and refuse writes; absent ones are work.
  task automatic t_own();
    l0_st = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
    l1_st = {16'h8888, 16'h7777, 16'h6666, 16'h5555};
    unit_fl = {16'hDDDD, 16'hCCCC, 16'hBBBB, 16'h02FF};
    acc(1'b1, 8'hEF, 16'hFFFF, 16'hFFFF);
    rc(8'hEF, 16'h2222);
    rc(`SFA_LINK1_BASE, 16'h5555);
    rc(`SFA_UNIT_BASE, 16'h0000);
    alt = 1'b1;
    rc(`SFA_LINK1_BASE, 16'h0000);
    rc(8'hF8, 16'h6666);
    net_p = 1'b0;
    alt = 1'b0;
    acc(1'b1, `SFA_LINK0_BASE, 16'hABCD, 16'hFFFF);
    rc(`SFA_LINK0_BASE, 16'hABCD);
    acc(1'b1, `SFA_UNIT_BASE, 16'h1234, 16'hFFFF);
    rc(`SFA_UNIT_BASE, 16'h1234);
    acc(1'b1, `SFA_UNUSED, 16'h5A5A, 16'hFFFF);
    rc(`SFA_UNUSED, 16'h5A5A);
    pcl_p = 1'b1;
    rc(`SFA_UNIT_BASE, 16'h02FF);
  endtask
  // Two queued errors stepped out by the check bit.
  task automatic t_rio();
    rio_p = 1'b1;
    push(20'h9A800);
    push(20'h00095);
    rc(`SFA_RIO_INFO, 16'hB358);
    rc(`SFA_ALARM, 16'h1000, 16'h1000);
    acc(1'b1, `SFA_RIO_INFO, 16'hFFFE, 16'hFFFE);
    acc(1'b1, `SFA_RIO_INFO, 16'h0001, 16'h0001);
    rc(`SFA_RIO_INFO, 16'hB359);
    acc(1'b1, `SFA_RIO_INFO, 16'h0000, 16'h0001);
    rc(`SFA_RIO_INFO, 16'h1258);
    acc(1'b1, `SFA_RIO_INFO, 16'h0001, 16'h0001);
    acc(1'b1, `SFA_RIO_INFO, 16'h0000, 16'h0001);
    rc(`SFA_RIO_INFO, 16'h0000);
    rc(`SFA_ALARM, 16'h0000, 16'h1000);
  endtask
  // Control bits, output off, retention and both restarts.
  task automatic t_ctl();
    multi = 1'b1;
    img = 16'hA5C3;
    acc(1'b1, `SFA_CTRL, 16'hFFFF, 16'hFFFF);
    rc(`SFA_CTRL, 16'hFE00);
    chk(phys, 16'h0000);
    watch(1'b1, 16'h0000);
    acc(1'b1, `SFA_CTRL, 16'h0000, 16'hFFFF);
    watch(1'b0, 16'h0100);
    chk(phys, 16'hA5C3);
    watch(1'b1, 16'h0001);
    multi = 1'b0;
    acc(1'b1, `SFA_CTRL, 16'h2000, 16'h2000);
    acc(1'b1, `SFA_CTRL, 16'h0000, 16'h2000);
    watch(1'b0, 16'h0010);
  endtask
  // Alarm number, system flags, step flag and result flags.
  task automatic t_sys();
    fal_v = 1'b1;
    fal_code = 8'h42;
    res_v = 1'b1;
    res = 5'h16;
    {batt, cyc, iover, hl_l0, first, step} = 6'h3F;
    @(negedge clk);
    fal_v = 1'b0;
    res_v = 1'b0;
    rc(`SFA_ALARM, 16'hAF42);
    rc(`SFA_SLOW, 16'h0080, 16'h0080);
    rc(`SFA_PULSE, 16'h0068, 16'h00F8);
    {batt, cyc, iover, hl_l0, first, step} = 6'h00;
    rc(`SFA_ALARM, 16'h2000, 16'hFF00);
  endtask
  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {en, we, addr, wdata, wmask, net_p, alt, pcl_p, rio_p, multi} = '0;
    {net_done, net_en, l0_act, l1_act, l0_st, l1_st, unit_fl} = '0;
    {rio_v, rio_info, hl_l0, hl_l1, hl_cpu, fal_v, fal_code} = '0;
    {batt, cyc, iover, first, step, res_v, res, img, mode} = '0;
    net_code = SFA_NORMAL;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_net();
    t_own();
    t_rio();
    t_ctl();
    t_sys();
    tr(`SFA_SLOW, 1, 16, 4);
    tr(`SFA_PULSE, 0, 40, 2);
    tr(`SFA_PULSE, 1, 80, 2);
    tr(`SFA_PULSE, 2, 400, 2);
    tr(`SFA_SLOW, 0, 24000, 2);
    end_sim();
  end
endmodule
`default_nettype wire
